// ==== ccmpc_pkg.sv ====
`default_nettype none
// ************************************************
// clock mode and pll control constants
// ************************************************
package ccmpc_pkg;
   // core clock rate
   localparam int CLK_HZ = 200_000_000;
   // register port widths
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] CLKSEL_ADDR = 4'h1;
   localparam logic [3:0] STATUS_ADDR = 4'h2;
   // control field positions
   localparam int CTRL_PLL_BIT = 0;
   localparam int CTRL_MS_BIT = 1;
   localparam int CTRL_MASTER_CLOCK_OUTPUT_BIT = 2;
   localparam int CTRL_PD_BIT = 3;
   localparam int CTRL_BCK_LSB = 4;
   // clock select field positions
   localparam int SEL_REF_LSB = 0;
   localparam int SEL_FS_LSB = 4;
   // reset values: slave, pll off, pull-down on
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam logic [7:0] CLKSEL_RESET = 8'h00;
   // lock times in ms, then cycles
   localparam int LOCK_FRAME_MS = 160;
   localparam int LOCK_BIT_MS = 2;
   localparam int LOCK_MCLK_MS = 40;
   localparam int LOCK_FRAME_CYC = CLK_HZ / 1000 * LOCK_FRAME_MS;
   localparam int LOCK_BIT_CYC = CLK_HZ / 1000 * LOCK_BIT_MS;
   localparam int LOCK_MCLK_CYC = CLK_HZ / 1000 * LOCK_MCLK_MS;
   // reference activity window, longer than one slowest frame
   localparam logic [15:0] ACT_TIMEOUT = 16'hffff;
   // phase step per Hz of fs, scaled by 2^16
   localparam longint NCO_K = (64'h1 << 48) / CLK_HZ;
   localparam int NCO_SHIFT = 16;
   // phase accumulator taps
   localparam int TAP_FS = 31;
   localparam int TAP_16FS = 27;
   localparam int TAP_256FS = 23;
   // clock scheme, one-hot
   typedef enum logic [3:0] {
      MODE_EXT_SLAVE = 4'b0001,
      MODE_PLL_SLAVE = 4'b0010,
      MODE_PLL_MASTER = 4'b0100,
      MODE_INVALID = 4'b1000
   } ccmpc_mode_type;
endpackage : ccmpc_pkg
`default_nettype wire

// ==== ccmpc_clock_ctrl.sv ====
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - scheme from pll power and master bit
// - master without pll drives meaningless clocks
// - pull-down bit zero with external clock
// - pull-down enabled only while bit set
// - master bit one master, zero slave
// - slave after reset until software writes
// - frame and bit pins undriven until master
// - pll clocking from reference and rate
// - unlocked for lock time after change
// - reference codes zero to three decode
// - master clock reference codes, others unsupported
// - master clock reference uses full rate
// - exact rate table for master clock
// - frame or bit reference ignores bit two
// - rate ranges for frame or bit reference
// - master clock out 256fs when enabled with pll on
// - bit clock 16, 32, 64fs by code
// - unlocked master holds frame and bit low
// - external slave ratio from rate field
module ccmpc_clock_ctrl #(
   parameter int LOCK_FRAME_CYC = ccmpc_pkg::LOCK_FRAME_CYC,
   parameter int LOCK_BIT_CYC = ccmpc_pkg::LOCK_BIT_CYC,
   parameter int LOCK_MCLK_CYC = ccmpc_pkg::LOCK_MCLK_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // register port
   input wire logic [ccmpc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [ccmpc_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   output logic [ccmpc_pkg::DATA_W-1:0] regRdData,
   // clock pins in
   input wire logic masterClockInput,
   input wire logic frameClockIn,
   input wire logic bitClockIn,
   // clock pins out
   output logic frameClockOut,
   output logic frameClockOe,
   output logic bitClockOut,
   output logic bitClockOe,
   output logic masterClockOutput,
   output logic masterClockInputPulldown,
   // status
   output logic pllLocked
);

   // ************************************************
   // registers and fields
   // ************************************************
   logic [7:0] ctrlReg; // control bits
   logic [7:0] clkSelReg; // reference and rate select
   logic pllPowerEnable;
   logic masterSelect;
   logic mckoEnable;
   logic [1:0] bitClockOutputRate;
   logic [3:0] pllReferenceSelect;
   logic [3:0] sampleRateSelect;
   logic referenceSelectBit2;

   assign pllPowerEnable = ctrlReg[ccmpc_pkg::CTRL_PLL_BIT];
   assign masterSelect = ctrlReg[ccmpc_pkg::CTRL_MS_BIT];
   assign mckoEnable = ctrlReg[ccmpc_pkg::CTRL_MASTER_CLOCK_OUTPUT_BIT];
   assign bitClockOutputRate = ctrlReg[ccmpc_pkg::CTRL_BCK_LSB +: 2];
   assign pllReferenceSelect = clkSelReg[ccmpc_pkg::SEL_REF_LSB +: 4];
   assign sampleRateSelect = clkSelReg[ccmpc_pkg::SEL_FS_LSB +: 4];
   assign referenceSelectBit2 = pllReferenceSelect[2];

   // ************************************************
   // decode functions
   // ************************************************
   // nominal fs in Hz, zero when unsupported
   function automatic logic [15:0] rate_hz(input logic [3:0] refSel, input logic [3:0] fs);
      logic [15:0] hz;
      hz = 16'h0000;
      if (refSel[2]) begin
         case (fs)
            4'h0: hz = 16'd8000;
            4'h1: hz = 16'd12000;
            4'h2: hz = 16'd16000;
            4'h3: hz = 16'd24000;
            4'h4: hz = 16'd7350;
            4'h5: hz = 16'd11025;
            4'h6: hz = 16'd14700;
            4'h7: hz = 16'd22050;
            4'ha: hz = 16'd32000;
            4'hb: hz = 16'd48000;
            4'he: hz = 16'd29400;
            4'hf: hz = 16'd44100;
            default: hz = 16'h0000;
         endcase
      end else begin
         case ({fs[3], fs[1:0]})
            3'h0: hz = 16'd8000;
            3'h1: hz = 16'd12000;
            3'h2: hz = 16'd16000;
            3'h3: hz = 16'd24000;
            3'h6: hz = 16'd32000;
            3'h7: hz = 16'd48000;
            default: hz = 16'h0000;
         endcase
      end
      return hz;
   endfunction : rate_hz

   function automatic logic ref_supported(input logic [3:0] refSel);
      case (refSel)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'hd: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : ref_supported

   function automatic logic [31:0] lock_cycles(input logic [3:0] refSel);
      if (refSel[2]) begin
         return 32'(LOCK_MCLK_CYC);
      end else if (refSel == 4'h0) begin
         return 32'(LOCK_FRAME_CYC);
      end else begin
         return 32'(LOCK_BIT_CYC);
      end
   endfunction : lock_cycles

   // ************************************************
   // register writes
   // ************************************************
   // control register, reset gives slave with pull-down
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ctrlReg <= ccmpc_pkg::CTRL_RESET;
      end else if (regWrStrobe && regAddr == ccmpc_pkg::CTRL_ADDR) begin
         ctrlReg <= regWrData;
      end
   end

   // clock select register
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         clkSelReg <= ccmpc_pkg::CLKSEL_RESET;
      end else if (regWrStrobe && regAddr == ccmpc_pkg::CLKSEL_ADDR) begin
         clkSelReg <= regWrData;
      end
   end

   // ************************************************
   // clock scheme
   // ************************************************
   ccmpc_pkg::ccmpc_mode_type modeReg;
   ccmpc_pkg::ccmpc_mode_type modeNext;

   always_comb begin
      case ({pllPowerEnable, masterSelect})
         2'b11: modeNext = ccmpc_pkg::MODE_PLL_MASTER;
         2'b10: modeNext = ccmpc_pkg::MODE_PLL_SLAVE;
         2'b01: modeNext = ccmpc_pkg::MODE_INVALID;
         default: modeNext = ccmpc_pkg::MODE_EXT_SLAVE;
      endcase
   end

   // registered scheme
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         modeReg <= ccmpc_pkg::MODE_EXT_SLAVE;
      end else begin
         modeReg <= modeNext;
      end
   end

   // ************************************************
   // pin synchronisers
   // ************************************************
   logic [2:0] pinMeta; // first stage, read only by second
   logic [2:0] pinSync; // {master, bit, frame}
   logic [2:0] pinPrev; // for edge detect

   // two flops then an edge register
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pinMeta <= 3'h0;
         pinSync <= 3'h0;
         pinPrev <= 3'h0;
      end else begin
         pinMeta <= {masterClockInput, bitClockIn, frameClockIn};
         pinSync <= pinMeta;
         pinPrev <= pinSync;
      end
   end

   // rising edge of the selected reference
   logic refEdge;
   logic [2:0] pinRise;
   assign pinRise = pinSync & ~pinPrev;
   assign refEdge = referenceSelectBit2 ? pinRise[2] :
                    (pllReferenceSelect == 4'h0) ? pinRise[0] : pinRise[1];

   // ************************************************
   // reference activity
   // ************************************************
   logic [15:0] actCnt; // cycles since last reference edge
   logic refActive;
   assign refActive = (actCnt != ccmpc_pkg::ACT_TIMEOUT);

   // saturating counter restarted by each edge
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         actCnt <= ccmpc_pkg::ACT_TIMEOUT;
      end else if (refEdge) begin
         actCnt <= 16'h0000;
      end else if (refActive) begin
         actCnt <= actCnt + 16'h0001;
      end
   end

   // ************************************************
   // lock tracking
   // ************************************************
   logic pllPrev; // previous pll power bit
   logic [7:0] clkSelPrev; // previous select value
   logic restart;
   logic [31:0] lockCnt;
   logic lockedReg;
   logic refBad;
   logic rateBad;
   assign refBad = ~ref_supported(pllReferenceSelect);
   assign rateBad = (rate_hz(pllReferenceSelect, sampleRateSelect) == 16'h0000);

   // restart on power-up or any clock select change, reference or rate
   assign restart = (pllPowerEnable && !pllPrev) || (clkSelReg != clkSelPrev);

   // change detect history
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pllPrev <= 1'b0;
         clkSelPrev <= ccmpc_pkg::CLKSEL_RESET;
      end else begin
         pllPrev <= pllPowerEnable;
         clkSelPrev <= clkSelReg;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n || !pllPowerEnable || restart || refBad || rateBad) begin
         lockCnt <= 32'h0;
         lockedReg <= 1'b0;
      end else if (!lockedReg && refActive) begin
         // count only while the reference is alive
         if (lockCnt + 32'h1 >= lock_cycles(pllReferenceSelect)) begin
            lockedReg <= 1'b1;
         end
         lockCnt <= lockCnt + 32'h1;
      end
   end

   // ************************************************
   // phase accumulator
   // ************************************************
   logic [31:0] phaseStep;
   logic [31:0] phaseReg;
   logic [63:0] stepWide;
   assign stepWide = 64'(rate_hz(pllReferenceSelect, sampleRateSelect)) * ccmpc_pkg::NCO_K;

   always_ff @(posedge ref_clk) begin
      if (!reset_n || !pllPowerEnable) begin
         phaseStep <= 32'h0;
         phaseReg <= 32'h0;
      end else begin
         phaseStep <= stepWide[ccmpc_pkg::NCO_SHIFT +: 32];
         phaseReg <= phaseReg + phaseStep;
      end
   end

   // bit clock tap by rate code
   logic bitTap;
   always_comb begin
      case (bitClockOutputRate)
         2'b00: bitTap = phaseReg[ccmpc_pkg::TAP_16FS];
         2'b01: bitTap = phaseReg[ccmpc_pkg::TAP_16FS - 1];
         2'b10: bitTap = phaseReg[ccmpc_pkg::TAP_16FS - 2];
         default: bitTap = 1'b0;
      endcase
   end

   // ************************************************
   // pin outputs
   // ************************************************
   // frame and bit clock drive
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         frameClockOut <= 1'b0;
         frameClockOe <= 1'b0;
         bitClockOut <= 1'b0;
         bitClockOe <= 1'b0;
      end else begin
         // drive only with master bit set
         frameClockOe <= masterSelect;
         bitClockOe <= masterSelect;
         case (modeReg)
            ccmpc_pkg::MODE_PLL_MASTER: begin
               frameClockOut <= lockedReg & phaseReg[ccmpc_pkg::TAP_FS];
               bitClockOut <= lockedReg & bitTap;
            end
            ccmpc_pkg::MODE_INVALID: begin
               frameClockOut <= pinSync[2];
               bitClockOut <= pinSync[2];
            end
            default: begin
               frameClockOut <= 1'b0;
               bitClockOut <= 1'b0;
            end
         endcase
      end
   end

   // master clock out and pull-down
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         masterClockOutput <= 1'b0;
         masterClockInputPulldown <= 1'b1;
      end else begin
         masterClockInputPulldown <= ctrlReg[ccmpc_pkg::CTRL_PD_BIT];
         case (modeReg)
            ccmpc_pkg::MODE_PLL_MASTER, ccmpc_pkg::MODE_PLL_SLAVE: begin
               masterClockOutput <= mckoEnable & phaseReg[ccmpc_pkg::TAP_256FS];
            end
            ccmpc_pkg::MODE_INVALID: begin
               masterClockOutput <= mckoEnable & pinSync[2];
            end
            default: masterClockOutput <= 1'b0;
         endcase
      end
   end

   // lock status pin
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pllLocked <= 1'b0;
      end else begin
         pllLocked <= lockedReg;
      end
   end

   // ************************************************
   // status and read port
   // ************************************************
   // external ratio: 0=256fs 1=512fs 2=1024fs
   logic [1:0] extRatio;
   assign extRatio = (sampleRateSelect[1:0] == 2'b01) ? 2'h2 :
                     (sampleRateSelect[1:0] == 2'b11) ? 2'h1 : 2'h0;

   // scheme as a two-bit index
   logic [1:0] modeIdx;
   always_comb begin
      case (modeReg)
         ccmpc_pkg::MODE_PLL_SLAVE: modeIdx = 2'h1;
         ccmpc_pkg::MODE_PLL_MASTER: modeIdx = 2'h2;
         ccmpc_pkg::MODE_INVALID: modeIdx = 2'h3;
         default: modeIdx = 2'h0;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !regRdStrobe) begin
         regRdData <= 8'h00;
      end else begin
         case (regAddr)
            ccmpc_pkg::CTRL_ADDR: regRdData <= ctrlReg;
            ccmpc_pkg::CLKSEL_ADDR: regRdData <= clkSelReg;
            ccmpc_pkg::STATUS_ADDR: regRdData <= {extRatio, modeIdx, rateBad, refBad,
                                                  refActive, lockedReg};
            default: regRdData <= 8'h00;
         endcase
      end
   end

endmodule : ccmpc_clock_ctrl
`default_nettype wire

// ==== ccmpc_clock_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************
// port checker
// ************************
module ccmpc_clock_ctrl_chk #(
   parameter int LOCK_BIT_CYC = 40
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   input wire logic [7:0] regRdData,
   // clock pins
   input wire logic masterClockInput,
   input wire logic frameClockIn,
   input wire logic bitClockIn,
   input wire logic frameClockOut,
   input wire logic frameClockOe,
   input wire logic bitClockOut,
   input wire logic bitClockOe,
   input wire logic masterClockOutput,
   input wire logic masterClockInputPulldown,
   input wire logic pllLocked
);
   logic [7:0] ctrlShadow; // copy of the control register
   logic [15:0] sinceWr; // cycles since the last write
   // shadow control writes, count quiet cycles
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ctrlShadow <= ccmpc_pkg::CTRL_RESET;
         sinceWr <= 16'h0000;
      end else if (regWrStrobe) begin
         sinceWr <= 16'h0000;
         if (regAddr == ccmpc_pkg::CTRL_ADDR)
            ctrlShadow <= regWrData;
      end else if (sinceWr != 16'hffff) begin
         sinceWr <= sinceWr + 16'h0001;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // write to the control register
   sequence ctrlWr;
      regWrStrobe && regAddr == ccmpc_pkg::CTRL_ADDR;
   endsequence
   AST_OE_PAIR: assert property (frameClockOe == bitClockOe)
      else $error("frame and bit drive enables differ");
   AST_RESET_SLAVE: assert property ($rose(reset_n) |-> !frameClockOe && masterClockInputPulldown)
      else $error("not slave with pull-down after reset");
   AST_MASTER_ON: assert property (ctrlWr ##0 regWrData[1] |-> ##[1:3] frameClockOe)
      else $error("master bit did not enable clock drivers");
   AST_OE_CAUSE: assert property ($rose(frameClockOe) |-> sinceWr <= 3 && ctrlShadow[1])
      else $error("clock drivers enabled without master bit");
   AST_PD_FOLLOW: assert property ($changed(masterClockInputPulldown) |->
      masterClockInputPulldown == ctrlShadow[3] && sinceWr <= 3)
      else $error("pull-down differs from its bit");
   AST_UNLOCK_LOW: assert property (ctrlShadow[1:0] == 2'b11 && sinceWr > 4 && !pllLocked
      && !$past(pllLocked) && !$past(pllLocked, 2) |-> !frameClockOut && !bitClockOut)
      else $error("master clocks run while unlocked");
   AST_MASTER_CLOCK_OUTPUT_OFF: assert property (sinceWr > 4 && (!ctrlShadow[2] || ctrlShadow[1:0] == 2'b00)
      |-> !masterClockOutput)
      else $error("master clock out not low");
   AST_LOCK_TIME: assert property ($rose(pllLocked) |-> sinceWr >= LOCK_BIT_CYC && ctrlShadow[0])
      else $error("lock flag rose too early");
   AST_LOCK_DROP: assert property (ctrlWr ##0 !regWrData[0] |-> ##[1:3] !pllLocked)
      else $error("lock flag kept with pll off");
endmodule : ccmpc_clock_ctrl_chk
bind ccmpc_clock_ctrl ccmpc_clock_ctrl_chk #(.LOCK_BIT_CYC(LOCK_BIT_CYC)) chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
   .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
   .masterClockInput(masterClockInput), .frameClockIn(frameClockIn), .bitClockIn(bitClockIn),
   .frameClockOut(frameClockOut), .frameClockOe(frameClockOe), .bitClockOut(bitClockOut),
   .bitClockOe(bitClockOe), .masterClockOutput(masterClockOutput),
   .masterClockInputPulldown(masterClockInputPulldown), .pllLocked(pllLocked));
`default_nettype wire

// ==== ccmpc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************
// host audio processor
// ************************
module ccmpc_host_model (
   // bench control
   input wire logic runClocks,
   input wire logic applyMclk,
   // device pin state
   input wire logic masterClockInputPulldown,
   // clocks to the device
   output logic masterClockInput,
   output logic frameClockIn,
   output logic bitClockIn
);
   logic linkClk; // 48 ns link clock source
   logic mclkRaw; // 20 ns master clock source
   logic [4:0] bitCnt; // bit position in a frame
   // free running sources
   initial begin
      linkClk = 1'b0;
      forever #24 linkClk = ~linkClk;
   end
   initial begin
      mclkRaw = 1'b0;
      forever #10 mclkRaw = ~mclkRaw;
   end
   // bit clock stands still while runClocks is low
   assign bitClockIn = linkClk & runClocks;
   // frame clock at one in 32 bit clocks
   always @(negedge linkClk) begin
      if (!runClocks)
         bitCnt <= 5'h00;
      else
         bitCnt <= bitCnt + 5'h01;
   end
   assign frameClockIn = runClocks & bitCnt[4];
   assign masterClockInput = mclkRaw & applyMclk & !masterClockInputPulldown;
endmodule : ccmpc_host_model
`default_nettype wire

// ==== ccmpc_clock_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ************************
// bench top
// ************************
module ccmpc_clock_ctrl_tb;
   localparam int LOCK_CYC = 40; // shortened bit clock lock time
   logic ref_clk; // core clock
   logic reset_n; // reset, active low
   logic [3:0] regAddr; // register address
   logic [7:0] regWrData; // write data
   logic regWrStrobe; // write strobe
   logic regRdStrobe; // read strobe
   logic [7:0] regRdData; // read data
   logic masterClockInput, frameClockIn, bitClockIn; // host clocks
   logic frameClockOut, frameClockOe, bitClockOut, bitClockOe; // device clocks
   logic masterClockOutput, masterClockInputPulldown, pllLocked; // device state
   logic runClocks, applyMclk; // host control
   int mismatches, cmpCount; // result counters
   logic [7:0] rdv; // last read value
   ccmpc_clock_ctrl #(.LOCK_FRAME_CYC(200), .LOCK_BIT_CYC(LOCK_CYC), .LOCK_MCLK_CYC(100)) dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
      .masterClockInput(masterClockInput), .frameClockIn(frameClockIn), .bitClockIn(bitClockIn),
      .frameClockOut(frameClockOut), .frameClockOe(frameClockOe), .bitClockOut(bitClockOut),
      .bitClockOe(bitClockOe), .masterClockOutput(masterClockOutput),
      .masterClockInputPulldown(masterClockInputPulldown), .pllLocked(pllLocked));
   ccmpc_host_model host (.runClocks(runClocks), .applyMclk(applyMclk),
      .masterClockInputPulldown(masterClockInputPulldown), .masterClockInput(masterClockInput),
      .frameClockIn(frameClockIn), .bitClockIn(bitClockIn));
   // core clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // verdict
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmpCount, mismatches);
      if (mismatches == 0 && cmpCount > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   // a wait ran out
   task automatic fail_wait();
      mismatches++;
      $display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
      end_of_test();
   endtask : fail_wait
   // bus write, one cycle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge ref_clk);
      regWrStrobe <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   // bus read, data the cycle after
   task automatic rd(input logic [3:0] a);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge ref_clk);
      regRdStrobe <= 1'b0;
      #1 rdv = regRdData;
      @(posedge ref_clk);
   endtask : rd
   // wait for lock, count cycles
   task automatic wait_lock(output int cyc);
      cyc = 0;
      while (pllLocked !== 1'b1) begin
         @(posedge ref_clk);
         cyc++;
         if (cyc > 3000)
            fail_wait();
      end
   endtask : wait_lock
   // count bit and master clock rises in one frame
   task automatic measure(output int bits, output int mcks);
      int k, fr;
      logic pf, pb, pm;
      bits = 0;
      mcks = 0;
      fr = 0;
      k = 0;
      pf = frameClockOut;
      pb = bitClockOut;
      pm = masterClockOutput;
      while (fr < 2) begin
         @(posedge ref_clk);
         if (frameClockOut && !pf)
            fr++;
         if (fr == 1 && bitClockOut && !pb)
            bits++;
         if (fr == 1 && masterClockOutput && !pm)
            mcks++;
         pf = frameClockOut;
         pb = bitClockOut;
         pm = masterClockOutput;
         k++;
         if (k > 12000)
            fail_wait();
      end
   endtask : measure
   // reset state
   task automatic t_reset();
      `CHK(frameClockOe, 1'b0);
      `CHK(masterClockInputPulldown, 1'b1);
      rd(ccmpc_pkg::CTRL_ADDR);
      `CHK(rdv, ccmpc_pkg::CTRL_RESET);
      rd(ccmpc_pkg::CLKSEL_ADDR);
      `CHK(rdv, 8'h00);
      $display("t_reset done");
   endtask : t_reset
   // pull-down bit, external master clock
   task automatic t_ext();
      logic [1:0] ratio [4] = '{2'h0, 2'h2, 2'h0, 2'h1};
      applyMclk <= 1'b1;
      wr(ccmpc_pkg::CTRL_ADDR, 8'h00);
      repeat (3) @(posedge ref_clk);
      `CHK(masterClockInputPulldown, 1'b0);
      for (int r = 0; r < 4; r++) begin
         wr(ccmpc_pkg::CLKSEL_ADDR, {6'h00, r[1:0]} << 4);
         rd(ccmpc_pkg::STATUS_ADDR);
         `CHK(rdv[7:6], ratio[r]);
      end
      applyMclk <= 1'b0;
      wr(ccmpc_pkg::CTRL_ADDR, 8'h08);
      repeat (3) @(posedge ref_clk);
      `CHK(masterClockInputPulldown, 1'b1);
      $display("t_ext done");
   endtask : t_ext
   // clock scheme decode
   task automatic t_modes();
      logic [1:0] mode [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
      for (int m = 0; m < 4; m++) begin
         wr(ccmpc_pkg::CTRL_ADDR, {6'h02, m[1:0]});
         repeat (3) @(posedge ref_clk);
         `CHK(frameClockOe, m[1]);
         `CHK(bitClockOe, m[1]);
         rd(ccmpc_pkg::STATUS_ADDR);
         `CHK(rdv[5:4], mode[m]);
      end
      wr(ccmpc_pkg::CTRL_ADDR, 8'h08);
      $display("t_modes done");
   endtask : t_modes
   // pll master, lock and generated clocks
   task automatic t_master();
      int n, bits, mcks;
      runClocks <= 1'b1;
      wr(ccmpc_pkg::CLKSEL_ADDR, 8'hb2);
      wr(ccmpc_pkg::CTRL_ADDR, 8'h0f);
      wait_lock(n);
      `CHK(n >= LOCK_CYC, 1'b1);
      for (int c = 0; c < 3; c++) begin
         wr(ccmpc_pkg::CTRL_ADDR, {2'h0, c[1:0], 4'hf});
         measure(bits, mcks);
         `CHK(bits, 16 << c);
         `CHK(mcks, 256);
      end
      wr(ccmpc_pkg::CTRL_ADDR, 8'h0b);
      measure(bits, mcks);
      `CHK(mcks, 0);
      wr(ccmpc_pkg::CLKSEL_ADDR, 8'hb3);
      repeat (3) @(posedge ref_clk);
      `CHK(pllLocked, 1'b0);
      `CHK(frameClockOut, 1'b0);
      `CHK(bitClockOut, 1'b0);
      wait_lock(n);
      `CHK(n + 3 >= LOCK_CYC, 1'b1);
      $display("t_master done");
   endtask : t_master
   // reference and rate code support
   task automatic t_codes();
      logic [9:0] tbl [7] = '{{8'h08, 2'h1}, {8'h84, 2'h2}, {8'h41, 2'h0}, {8'h51, 2'h0},
         {8'hc4, 2'h2}, {8'hd1, 2'h2}, {8'h0d, 2'h0}};
      for (int i = 0; i < 7; i++) begin
         wr(ccmpc_pkg::CLKSEL_ADDR, tbl[i][9:2]);
         rd(ccmpc_pkg::STATUS_ADDR);
         `CHK(rdv[3:2], tbl[i][1:0]);
      end
      wr(ccmpc_pkg::CLKSEL_ADDR, 8'h08);
      repeat (600) @(posedge ref_clk);
      `CHK(pllLocked, 1'b0);
      $display("t_codes done");
   endtask : t_codes
   // main sequence
   initial begin
      mismatches = 0;
      cmpCount = 0;
      reset_n = 1'b0;
      regAddr = 4'h0;
      regWrData = 8'h00;
      regWrStrobe = 1'b0;
      regRdStrobe = 1'b0;
      runClocks = 1'b0;
      applyMclk = 1'b0;
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_ext();
      t_modes();
      t_master();
      t_codes();
      end_of_test();
   end
endmodule : ccmpc_clock_ctrl_tb
`default_nettype wire
